// ### dv/gpm_ext_model.sv
// Behavioural model of the extended register set behind the indirect window.
// Assumes the same clock as the register bank and a combinational read path.
`timescale 1ns/10ps
module gpm_ext_model (
  // Clock
  input wire logic clk_sys_i,
  // Extended register port
  input wire logic [15:0] ext_ptr_i,
  input wire logic ext_wr_i,
  input wire logic [15:0] ext_waddr_i,
  input wire logic [15:0] ext_wdata_i,
  output logic [15:0] ext_rdata_o
);
  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Only the low four address bits decode, so the wrap from 0xFFFF to 0 lands on distinct entries.
  logic [15:0] mem [16];
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // Writes land at the edge after the bank's write pulse.
  always @(posedge clk_sys_i) begin
    if (ext_wr_i) mem[ext_waddr_i[3:0]] <= ext_wdata_i;
  end
  // Read data follows the pointer without delay, as the bank samples it in the request cycle.
  assign ext_rdata_o = mem[ext_ptr_i[3:0]];
endmodule : gpm_ext_model

// ### dv/testbench.sv
// Self-checking bench for the gigabit management register bank.
// Assumes one 100 MHz clock and the extended register model on the far side.
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [4:0] reg_addr_i = 5'h00;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic fd_strap_i = 1'b1, ms_fault_i = 1'b0, ms_master_i = 1'b0;
  logic local_rx_ok_i = 1'b0, remote_rx_ok_i = 1'b0, lp_gig_fd_i = 1'b0, lp_gig_hd_i = 1'b0;
  logic idle_err_i = 1'b0, link_down_i = 1'b0;
  logic [15:0] reg_rdata_o, ext_ptr_o, ext_rdata_i, ext_waddr_o, ext_wdata_o;
  logic reg_rvalid_o, ext_rd_o, ext_wr_o, ms_manual_en_o, ms_manual_master_o;
  logic port_multi_o, adv_gig_fd_o, adv_gig_hd_o, auto_cable_test_start_o;
  logic [2:0] test_mode_o;
  logic [15:0] exp_q[$];
  int miscompares = 0, check_count = 0, cycles = 0, ext_rd_count = 0;
  logic [15:0] d, s, d0, d1, d2, d3;
  gpm_regs i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .ext_ptr_o(ext_ptr_o), .ext_rdata_i(ext_rdata_i), .ext_rd_o(ext_rd_o), .ext_wr_o(ext_wr_o),
    .ext_waddr_o(ext_waddr_o), .ext_wdata_o(ext_wdata_o), .fd_strap_i(fd_strap_i), .ms_fault_i(ms_fault_i),
    .ms_master_i(ms_master_i), .local_rx_ok_i(local_rx_ok_i), .remote_rx_ok_i(remote_rx_ok_i),
    .lp_gig_fd_i(lp_gig_fd_i), .lp_gig_hd_i(lp_gig_hd_i), .idle_err_i(idle_err_i), .link_down_i(link_down_i),
    .test_mode_o(test_mode_o), .ms_manual_en_o(ms_manual_en_o), .ms_manual_master_o(ms_manual_master_o),
    .port_multi_o(port_multi_o), .adv_gig_fd_o(adv_gig_fd_o), .adv_gig_hd_o(adv_gig_hd_o),
    .auto_cable_test_start_o(auto_cable_test_start_o));
  gpm_ext_model i_ext (.clk_sys_i(clk_sys_i), .ext_ptr_i(ext_ptr_o), .ext_wr_i(ext_wr_o),
    .ext_waddr_i(ext_waddr_o), .ext_wdata_i(ext_wdata_o), .ext_rdata_o(ext_rdata_i));
  // ----------------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------------
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // The tests need well under a thousand cycles, so a hang is cut short at 3000.
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      $display("MISMATCH run_length expected finish seen timeout");
      complete_run();
    end
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One request per cycle; the strobes are left up so back-to-back calls never assign twice in a step.
  task automatic op(input logic w, input logic r, input logic [4:0] a, input logic [15:0] wd, input logic [15:0] e);
    reg_wr_i = w;
    reg_rd_i = r;
    reg_addr_i = a;
    reg_wdata_i = wd;
    if (r) exp_q.push_back(e);
    @(posedge clk_sys_i);
    #1;
  endtask : op
  task automatic wr(input logic [4:0] a, input logic [15:0] wd);
    op(1'b1, 1'b0, a, wd, 16'h0000);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    op(1'b0, 1'b1, a, 16'h0000, e);
  endtask : rd
  task automatic idle(input int n);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
    end
  endtask : idle
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  // Read answers are one-cycle pulses, so they are taken at the falling edge where they have settled.
  always @(negedge clk_sys_i) begin
    if (ext_rd_o === 1'b1) ext_rd_count++;
    if (reg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected_answer", 16'h0000, 16'hFFFF);
      else check("reg_rdata_o", exp_q.pop_front(), reg_rdata_o);
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(23));
    repeat (12) @(posedge clk_sys_i);
    #1;
    rst_b_i = 1'b1;
    idle(4);
    // Reset values, with the full duplex strap held high, and an unmapped offset.
    rd(gpm_pkg::OFF_GIG_CTL, 16'h0300);
    rd(gpm_pkg::OFF_GIG_STS, 16'h0000);
    rd(gpm_pkg::OFF_IND_CTL, 16'h0000);
    rd(5'h05, 16'h0000);
    idle(2);
    $display("test reset_values done");
    // Every test code, with random control bits, then a link drop per pass.
    for (int i = 0; i < 8; i++) begin
      d = {i[2:0], 13'($urandom())};
      wr(gpm_pkg::OFF_GIG_CTL, d);
      rd(gpm_pkg::OFF_GIG_CTL, d & gpm_pkg::CTL_WMASK);
      idle(1);
      check("test_mode_o", 16'(d[15:13]), 16'(test_mode_o));
      check("ms_controls", 16'(d[12:11]), 16'({ms_manual_en_o, ms_manual_master_o}));
      check("advertise", 16'(d[10:8]), 16'({port_multi_o, adv_gig_fd_o, adv_gig_hd_o}));
      link_down_i = 1'b1;
      idle(1);
      link_down_i = 1'b0;
      check("auto_cable_test_start_o", 16'(d[7]), 16'(auto_cable_test_start_o));
    end
    $display("test control_register done");
    // Live status bits, latched fault, idle count with clear on read and saturation.
    {ms_master_i, local_rx_ok_i, remote_rx_ok_i, lp_gig_fd_i, lp_gig_hd_i} = 5'($urandom());
    s = {1'b0, ms_master_i, local_rx_ok_i, remote_rx_ok_i, lp_gig_fd_i, lp_gig_hd_i, 10'h000};
    ms_fault_i = 1'b1;
    idle_err_i = 1'b1;
    idle(1);
    ms_fault_i = 1'b0;
    idle(4);
    idle_err_i = 1'b0;
    idle(3);
    rd(gpm_pkg::OFF_GIG_STS, s | 16'h8005);
    rd(gpm_pkg::OFF_GIG_STS, s);
    idle_err_i = 1'b1;
    idle(300);
    idle_err_i = 1'b0;
    rd(gpm_pkg::OFF_GIG_STS, s | 16'h00FF);
    idle(2);
    $display("test status_register done");
    // Indirect window: each function, pointer wrap and the device select filter.
    {d0, d1, d2, d3} = {16'($urandom()), 16'($urandom()), 16'($urandom()), 16'($urandom())};
    wr(gpm_pkg::OFF_IND_CTL, 16'hFFFF);
    rd(gpm_pkg::OFF_IND_CTL, 16'hC01F);
    wr(gpm_pkg::OFF_IND_CTL, 16'h001F);
    wr(gpm_pkg::OFF_IND_ADD, 16'hFFFE);
    rd(gpm_pkg::OFF_IND_ADD, 16'hFFFE);
    wr(gpm_pkg::OFF_IND_CTL, 16'h801F);
    wr(gpm_pkg::OFF_IND_ADD, d0);
    wr(gpm_pkg::OFF_IND_ADD, d1);
    wr(gpm_pkg::OFF_IND_CTL, 16'h001F);
    rd(gpm_pkg::OFF_IND_ADD, 16'h0000);
    wr(gpm_pkg::OFF_IND_ADD, 16'hFFFE);
    wr(gpm_pkg::OFF_IND_CTL, 16'h401F);
    rd(gpm_pkg::OFF_IND_ADD, d0);
    rd(gpm_pkg::OFF_IND_ADD, d0);
    wr(gpm_pkg::OFF_IND_CTL, 16'hC01F);
    rd(gpm_pkg::OFF_IND_ADD, d0);
    rd(gpm_pkg::OFF_IND_ADD, d0);
    wr(gpm_pkg::OFF_IND_ADD, d2);
    rd(gpm_pkg::OFF_IND_ADD, d1);
    wr(gpm_pkg::OFF_IND_CTL, 16'h801F);
    rd(gpm_pkg::OFF_IND_ADD, d1);
    wr(gpm_pkg::OFF_IND_CTL, 16'h401F);
    wr(gpm_pkg::OFF_IND_ADD, d3);
    // The extended write lands one edge after its pulse, so the read-back waits a cycle.
    idle(1);
    rd(gpm_pkg::OFF_IND_ADD, d3);
    wr(gpm_pkg::OFF_IND_CTL, 16'h001E);
    wr(gpm_pkg::OFF_IND_ADD, 16'h1234);
    rd(gpm_pkg::OFF_IND_ADD, 16'h0000);
    wr(gpm_pkg::OFF_IND_CTL, 16'h001F);
    rd(gpm_pkg::OFF_IND_ADD, 16'h0000);
    wr(gpm_pkg::OFF_IND_ADD, 16'hFFFE);
    wr(gpm_pkg::OFF_IND_CTL, 16'h401F);
    rd(gpm_pkg::OFF_IND_ADD, d2);
    idle(3);
    $display("test indirect_window done");
    check("answers_left", 16'h0000, 16'(exp_q.size()));
    check("ext_rd_pulses", 16'h0008, 16'(ext_rd_count));
    complete_run();
  end
endmodule : testbench

// ### hw/gpm_pkg.sv
// Constants for the gigabit management register bank.
// Assumes 5-bit management register addresses and 16-bit register data.
package gpm_pkg;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [4:0] OFF_GIG_CTL = 5'h09;
  localparam logic [4:0] OFF_GIG_STS = 5'h0A;
  localparam logic [4:0] OFF_IND_CTL = 5'h0D;
  localparam logic [4:0] OFF_IND_ADD = 5'h0E;
  // ----------------------------------------------------------------------
  // Gigabit control fields
  // ----------------------------------------------------------------------
  localparam int CTL_TEST_HI = 15;
  localparam int CTL_TEST_LO = 13;
  localparam int CTL_MS_EN = 12;
  localparam int CTL_MS_VAL = 11;
  localparam int CTL_PORT = 10;
  localparam int CTL_ADV_FD = 9;
  localparam int CTL_ADV_HD = 8;
  localparam int CTL_AUTO_TDR = 7;
  localparam logic [15:0] CTL_WMASK = 16'hFF80;
  localparam logic [15:0] CTL_RST = 16'h0100;
  localparam logic [2:0] TEST_NORMAL = 3'h0;
  // ----------------------------------------------------------------------
  // Gigabit status fields
  // ----------------------------------------------------------------------
  localparam int STS_FAULT = 15;
  localparam int STS_MASTER = 14;
  localparam int STS_LRX = 13;
  localparam int STS_RRX = 12;
  localparam int STS_LP_FD = 11;
  localparam int STS_LP_HD = 10;
  localparam logic [7:0] IDLE_MAX = 8'hFF;
  // ----------------------------------------------------------------------
  // Indirect access control fields
  // ----------------------------------------------------------------------
  localparam int IND_FN_HI = 15;
  localparam int IND_FN_LO = 14;
  localparam int IND_DEV_HI = 4;
  localparam int IND_DEV_LO = 0;
  localparam logic [1:0] FN_ADDR = 2'h0;
  localparam logic [1:0] FN_DATA = 2'h1;
  localparam logic [1:0] FN_INC_RW = 2'h2;
  localparam logic [1:0] FN_INC_WR = 2'h3;
  localparam logic [4:0] DEV_VENDOR = 5'h1F;
  localparam logic [15:0] PTR_RST = 16'h0000;
endpackage : gpm_pkg

// ### hw/gpm_regs.sv
// Gigabit control/status registers and the indirect extended-register window.
// Assumes the management frame engine and PHY core share clk_sys_i; only the
// full-duplex strap pin comes from outside and is synchronised here.
//
// Overview of operation
// - Test field 000 normal, 001-111 test patterns.
// - Manual enable bit selects configured master/slave role.
// - Manual value one means master, zero slave.
// - Conflicting manual role may fail link, allowed.
// - Configuration fault latches high, cleared by read.
// - Port type bit advertises multi or single port.
// - Advertise gigabit duplex; half resets one, full strap.
// - Auto cable test runs after each link drop.
// - Reserved bits ignore writes and read zero.
// - Status bit shows resolved master or slave.
// - Status bits show local and remote receiver health.
// - Status bits show partner gigabit duplex abilities.
// - Idle error count, cleared by status read.
// - Extended registers reached only through indirect pair.
// - Function 00: data write loads the pointer.
// - Function 01: access pointed register, pointer unchanged.
// - Function 10: pointer increments after every access.
// - Function 11: pointer increments after writes only.
// - Only target device 11111 honoured, others ignored.
// - Data register shows pointer or pointed register data.
`timescale 1ns/10ps
module gpm_regs (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Management register access from the frame engine
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Extended register set
  output logic [15:0] ext_ptr_o,
  input wire logic [15:0] ext_rdata_i,
  output logic ext_rd_o,
  output logic ext_wr_o,
  output logic [15:0] ext_waddr_o,
  output logic [15:0] ext_wdata_o,
  // PHY core status and events
  input wire logic fd_strap_i,
  input wire logic ms_fault_i,
  input wire logic ms_master_i,
  input wire logic local_rx_ok_i,
  input wire logic remote_rx_ok_i,
  input wire logic lp_gig_fd_i,
  input wire logic lp_gig_hd_i,
  input wire logic idle_err_i,
  input wire logic link_down_i,
  // PHY core controls
  output logic [2:0] test_mode_o,
  output logic ms_manual_en_o,
  output logic ms_manual_master_o,
  output logic port_multi_o,
  output logic adv_gig_fd_o,
  output logic adv_gig_hd_o,
  output logic auto_cable_test_start_o
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [15:0] ctl_r;
  logic fault_r;
  logic [7:0] idle_cnt_r;
  logic [1:0] fn_r;
  logic [4:0] dev_r;
  logic [15:0] ptr_r;
  logic strap_m_r;
  logic strap_s_r;
  logic init_done_r;
  logic [1:0] settle_r;
  logic wr_ctl;
  logic wr_ind;
  logic rd_sts;
  logic add_hit;
  logic add_wr;
  logic add_rd;
  logic [15:0] rdata_nxt;

  assign wr_ctl = reg_wr_i && (reg_addr_i == gpm_pkg::OFF_GIG_CTL);
  assign wr_ind = reg_wr_i && (reg_addr_i == gpm_pkg::OFF_IND_CTL);
  assign rd_sts = reg_rd_i && (reg_addr_i == gpm_pkg::OFF_GIG_STS);
  // Foreign device selects make the data register inert for both directions.
  assign add_hit = (reg_addr_i == gpm_pkg::OFF_IND_ADD) && (dev_r == gpm_pkg::DEV_VENDOR);
  assign add_wr = reg_wr_i && add_hit;
  // A simultaneous write wins, so a read is only seen when no write is present.
  assign add_rd = reg_rd_i && !reg_wr_i && add_hit;

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  // The strap is a pin, so it passes two flops before the control word uses it.
  // Only the second flop is read; a short shift of ones counts the edges the
  // synchroniser needs to fill, so the strap lands in the word on edge three.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      strap_m_r <= 1'b0;
      strap_s_r <= 1'b0;
      settle_r <= 2'h0;
      init_done_r <= 1'b0;
    end else begin
      strap_m_r <= fd_strap_i;
      strap_s_r <= strap_m_r;
      settle_r <= {settle_r[0], 1'b1};
      init_done_r <= settle_r[1];
    end
  end

  // ----------------------------------------------------------------------
  // Gigabit control register
  // ----------------------------------------------------------------------
  // The full-duplex default follows the strap until the synchroniser has
  // settled; a software write during that window keeps its other bits, but any later window edge reloads its full-duplex bit.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ctl_r <= gpm_pkg::CTL_RST;
    end else if (wr_ctl) begin
      ctl_r <= reg_wdata_i & gpm_pkg::CTL_WMASK;
    end else if (!init_done_r) begin
      ctl_r[gpm_pkg::CTL_ADV_FD] <= strap_s_r;
    end
  end

  // Control outputs are registered copies; a manual role that conflicts with
  // the partner is passed on unchanged and may simply never link.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      test_mode_o <= gpm_pkg::TEST_NORMAL;
      ms_manual_en_o <= 1'b0;
      ms_manual_master_o <= 1'b0;
      port_multi_o <= 1'b0;
      adv_gig_fd_o <= 1'b0;
      adv_gig_hd_o <= 1'b0;
    end else begin
      test_mode_o <= ctl_r[gpm_pkg::CTL_TEST_HI:gpm_pkg::CTL_TEST_LO];
      ms_manual_en_o <= ctl_r[gpm_pkg::CTL_MS_EN];
      ms_manual_master_o <= ctl_r[gpm_pkg::CTL_MS_VAL];
      port_multi_o <= ctl_r[gpm_pkg::CTL_PORT];
      adv_gig_fd_o <= ctl_r[gpm_pkg::CTL_ADV_FD];
      adv_gig_hd_o <= ctl_r[gpm_pkg::CTL_ADV_HD];
    end
  end

  // Automatic cable test launch, link_down_i gated by the enable bit and registered, so it stays high for as long as link_down_i does.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      auto_cable_test_start_o <= 1'b0;
    end else begin
      auto_cable_test_start_o <= link_down_i && ctl_r[gpm_pkg::CTL_AUTO_TDR];
    end
  end

  // ----------------------------------------------------------------------
  // Gigabit status latches
  // ----------------------------------------------------------------------
  // A fault or idle error in the read cycle survives the clear.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      fault_r <= 1'b0;
    end else if (ms_fault_i) begin
      fault_r <= 1'b1;
    end else if (rd_sts) begin
      fault_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      idle_cnt_r <= 8'h00;
    end else if (rd_sts) begin
      idle_cnt_r <= {7'h00, idle_err_i};
    end else if (idle_err_i && (idle_cnt_r != gpm_pkg::IDLE_MAX)) begin
      idle_cnt_r <= idle_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Indirect access control and pointer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      fn_r <= gpm_pkg::FN_ADDR;
      dev_r <= 5'h00;
    end else if (wr_ind) begin
      fn_r <= reg_wdata_i[gpm_pkg::IND_FN_HI:gpm_pkg::IND_FN_LO];
      dev_r <= reg_wdata_i[gpm_pkg::IND_DEV_HI:gpm_pkg::IND_DEV_LO];
    end
  end

  // The pointer is the only path to the extended set; it wraps naturally.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ptr_r <= gpm_pkg::PTR_RST;
    end else if (add_wr && (fn_r == gpm_pkg::FN_ADDR)) begin
      ptr_r <= reg_wdata_i;
    end else if (add_wr && ((fn_r == gpm_pkg::FN_INC_RW) || (fn_r == gpm_pkg::FN_INC_WR))) begin
      ptr_r <= ptr_r + 16'h0001;
    end else if (add_rd && (fn_r == gpm_pkg::FN_INC_RW)) begin
      ptr_r <= ptr_r + 16'h0001;
    end
  end

  assign ext_ptr_o = ptr_r;

  // The extended write strobe carries the address used, since the pointer may move on.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ext_wr_o <= 1'b0;
      ext_rd_o <= 1'b0;
      ext_waddr_o <= 16'h0000;
      ext_wdata_o <= 16'h0000;
    end else begin
      ext_wr_o <= add_wr && (fn_r != gpm_pkg::FN_ADDR);
      ext_rd_o <= add_rd && (fn_r != gpm_pkg::FN_ADDR);
      if (add_wr) begin
        ext_waddr_o <= ptr_r;
        ext_wdata_o <= reg_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Unmapped addresses and foreign device selects read as zero.
  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_addr_i == gpm_pkg::OFF_GIG_CTL) begin
      rdata_nxt = ctl_r;
    end else if (reg_addr_i == gpm_pkg::OFF_GIG_STS) begin
      rdata_nxt[gpm_pkg::STS_FAULT] = fault_r;
      rdata_nxt[gpm_pkg::STS_MASTER] = ms_master_i;
      rdata_nxt[gpm_pkg::STS_LRX] = local_rx_ok_i;
      rdata_nxt[gpm_pkg::STS_RRX] = remote_rx_ok_i;
      rdata_nxt[gpm_pkg::STS_LP_FD] = lp_gig_fd_i;
      rdata_nxt[gpm_pkg::STS_LP_HD] = lp_gig_hd_i;
      rdata_nxt[7:0] = idle_cnt_r;
    end else if (reg_addr_i == gpm_pkg::OFF_IND_CTL) begin
      rdata_nxt[gpm_pkg::IND_FN_HI:gpm_pkg::IND_FN_LO] = fn_r;
      rdata_nxt[gpm_pkg::IND_DEV_HI:gpm_pkg::IND_DEV_LO] = dev_r;
    end else if (add_hit) begin
      rdata_nxt = (fn_r == gpm_pkg::FN_ADDR) ? ptr_r : ext_rdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_nxt : 16'h0000;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  AST_TEST_MODE: assert property (wr_ctl |-> ##2 test_mode_o == $past(reg_wdata_i[15:13], 2))
    else $error("Test mode output does not follow the written field.");
  AST_MANUAL_ROLE: assert property (wr_ctl |-> ##2 (ms_manual_en_o == $past(reg_wdata_i[12], 2))
      && (ms_manual_master_o == $past(reg_wdata_i[11], 2)))
    else $error("Manual master/slave outputs do not follow the write.");
  AST_FAULT_LATCH: assert property (ms_fault_i |=> fault_r [*1] ##0 (rd_sts || fault_r))
    else $error("Configuration fault was not latched.");
  AST_FAULT_HOLD: assert property (fault_r && !rd_sts |=> fault_r)
    else $error("Configuration fault dropped without a status read.");
  AST_AUTO_TEST: assert property (link_down_i |=> auto_cable_test_start_o == $past(ctl_r[7]))
    else $error("Cable test launch does not match the enable bit.");
  AST_RSVD_ZERO: assert property (reg_rvalid_o && $past(reg_addr_i) == gpm_pkg::OFF_GIG_CTL
      |-> reg_rdata_o[6:0] == 7'h00)
    else $error("Reserved control bits read non-zero.");
  AST_STS_BITS: assert property (rd_sts |=> reg_rdata_o[14:10] == $past({ms_master_i,
      local_rx_ok_i, remote_rx_ok_i, lp_gig_fd_i, lp_gig_hd_i}))
    else $error("Status bits do not mirror the core.");
  AST_IDLE_CLEAR: assert property (rd_sts && !idle_err_i |=> idle_cnt_r == 8'h00)
    else $error("Idle error count not cleared by status read.");
  AST_IDLE_SAT: assert property (idle_cnt_r == 8'hFF && !rd_sts |=> idle_cnt_r == 8'hFF)
    else $error("Idle error count wrapped.");
  AST_PTR_LOAD: assert property (add_wr && fn_r == gpm_pkg::FN_ADDR |=> ptr_r == $past(reg_wdata_i))
    else $error("Pointer not loaded in address mode.");
  AST_PTR_KEEP: assert property ((add_wr || add_rd) && fn_r == gpm_pkg::FN_DATA |=> $stable(ptr_r))
    else $error("Pointer moved in no-increment mode.");
  AST_PTR_INC: assert property ((add_wr || add_rd) && fn_r == gpm_pkg::FN_INC_RW
      |=> ptr_r == $past(ptr_r) + 16'h0001)
    else $error("Pointer did not increment after access.");
  AST_RD_NOINC: assert property (add_rd && fn_r == gpm_pkg::FN_INC_WR |=> $stable(ptr_r))
    else $error("Pointer incremented on read in write-only mode.");
  AST_DEV_IGNORE: assert property (reg_wr_i && reg_addr_i == gpm_pkg::OFF_IND_ADD
      && dev_r != gpm_pkg::DEV_VENDOR |=> !ext_wr_o && $stable(ptr_r))
    else $error("Access with foreign device select took effect.");

  COV_EXT_WRITE: cover property (add_wr && fn_r == gpm_pkg::FN_INC_WR ##1 ext_wr_o);
  COV_FAULT_READ: cover property (fault_r && rd_sts ##1 !fault_r);
  COV_IDLE_SAT: cover property (idle_cnt_r == 8'hFF && idle_err_i);
  COV_AUTO_TEST: cover property (auto_cable_test_start_o);
endmodule : gpm_regs
